// ### core/cmbs_core.sv
// cmbs_core: boot option latch and clock generation control with AHB-Lite registers.
// assumes boot and oscillator status pins are asynchronous; clocks are modelled
// as one-cycle enable ticks of clk_sys, where every clk_sys cycle stands for f_sys.
`timescale 1ns/1ps
module cmbs_core
	import cmbs_pkg::*;
(
	input  logic             clk_sys,          // 40 MHz system clock
	input  logic             rstn,             // async reset, active low
	input  logic             hsel,             // ahb slave select
	input  logic [31:0]      haddr,            // ahb address
	input  logic [1:0]       htrans,           // ahb transfer type
	input  logic             hwrite,           // ahb write
	input  logic [2:0]       hsize,            // ahb size, word only
	input  logic [31:0]      hwdata,           // ahb write data
	input  logic             hready,           // ahb bus ready
	output logic [31:0]      hrdata,           // ahb read data
	output logic             hreadyout,        // ahb slave ready
	output logic             hresp,            // ahb response, always okay
	input  logic             modeBootPin,      // boot strap pin
	input  logic             tmsPin,           // test-mode-select pin
	input  logic             port0FirstPinIn,  // port0 first pin, input side
	output logic             clockOutputPinOut,// port0 first pin, output level
	output logic             clockOutputPinOe, // port0 first pin, output enable
	input  logic             flashProtected,   // flash read protection active
	input  logic             oscRunning,       // oscillator run detector
	input  logic             pllLocked,        // pll lock detector
	output cmbs_boot_type    bootInfo,         // latched boot option
	output cmbs_clk_cfg_type clkCfg,           // clock path configuration
	output logic             cpuClkTick,       // cpu clock enable tick
	output logic             periphClkTick,    // peripheral clock enable tick
	output logic             captureCompareClkTick, // capture-compare clock tick
	output logic             flashFastClkTick  // flash fast clock tick
);
	cmbs_ctrl_type       ctrl_ff;
	cmbs_pll_type        pll_ff;
	cmbs_boot_phase_type phase_ff;
	cmbs_boot_type       boot_ff;
	cmbs_clk_cfg_type    clkCfg_ff;
	cmbs_boot_mode_type  nxt_bootMode;
	cmbs_clk_mode_type   nxt_clkMode;
	cmbs_power_mode_type powerMode;

	logic [1:0]  settle_ff;
	logic        nxt_debugRefused;
	logic        nxt_jtag;
	logic [2:0]  pinSync;
	logic [2:0]  statSync;
	logic        oscRunPrev_ff;
	logic        pllLockPrev_ff;
	logic        oscFail_ff;
	logic        lockLost_ff;
	logic        wrPend_ff;
	logic [7:0]  wrAddr_ff;
	logic [31:0] rdata_ff;
	logic        hreadyout_ff;
	logic        addrPhase;
	logic [31:0] readMux;
	logic        sysRun;
	logic        baseTick;
	logic        slowTick;
	logic [3:0]  slowRatio;
	logic        cpuTick_ff;
	logic        periphTick_ff;
	logic        ccuTick_ff;
	logic        flashTick_ff;
	logic        selTick;
	logic        clock_output_pin_ff;
	logic        clkOutOe_ff;

	assign powerMode = cmbs_power_mode_type'(ctrl_ff.powerMode);

	cmbs_sync2 #(.WIDTH(3)) u_pin_sync (
		.clk_sys(clk_sys),
		.rstn   (rstn),
		.asyncIn({modeBootPin, tmsPin, port0FirstPinIn}),
		.syncOut(pinSync)
	);

	cmbs_sync2 #(.WIDTH(3)) u_stat_sync (
		.clk_sys(clk_sys),
		.rstn   (rstn),
		.asyncIn({flashProtected, oscRunning, pllLocked}),
		.syncOut(statSync)
	);

	// boot decode from synchronised strap levels
	always_comb
	begin
		nxt_bootMode     = BM_USER;
		nxt_debugRefused = 1'b0;
		nxt_jtag         = 1'b0;
		unique case ({pinSync[2], pinSync[1]})
			2'b10: nxt_bootMode = BM_USER;
			2'b00: nxt_bootMode = BM_LOADER;
			2'b01:
			begin
				if (!pinSync[0] && !statSync[2])
				begin
					nxt_bootMode = BM_DEBUG;
					nxt_jtag     = 1'b1;
				end
				else
				begin
					// refused or undefined combination falls back to user mode
					nxt_bootMode     = BM_USER;
					nxt_debugRefused = !pinSync[0];
				end
			end
			2'b11:
			begin
				nxt_bootMode = BM_USER_JTAG;
				nxt_jtag     = !pinSync[0];
			end
		endcase
	end

	// waits for the strap synchronisers to settle, then latches once
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_ff  <= BP_SYNC;
			settle_ff <= 2'h0;
			boot_ff   <= '0;
		end
		else
		begin
			unique case (phase_ff)
				BP_SYNC:
				begin
					settle_ff <= settle_ff + 2'h1;
					if (settle_ff == BOOT_SETTLE_CYC - 2'h1)
						phase_ff <= BP_LATCH;
				end
				BP_LATCH:
				begin
					boot_ff.bootMode       <= nxt_bootMode;
					boot_ff.bootValid      <= 1'b1;
					boot_ff.jtagPinsActive <= nxt_jtag;
					boot_ff.debugRefused   <= nxt_debugRefused;
					boot_ff.pcStart        <= PC_START;
					phase_ff               <= BP_DONE;
				end
				BP_DONE: phase_ff <= BP_DONE;
				default: phase_ff <= BP_SYNC;
			endcase
		end
	end

	// clock mode from disconnect and bypass bits
	always_comb
	begin
		if (pll_ff.oscDisconnect)
			nxt_clkMode = CM_PLL_BASE;
		else if (pll_ff.vcoBypass)
			nxt_clkMode = CM_PRESCALER;
		else
			nxt_clkMode = CM_PLL;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			clkCfg_ff <= '0;
		end
		else
		begin
			clkCfg_ff.clkMode      <= nxt_clkMode;
			clkCfg_ff.oscToPll     <= !pll_ff.oscDisconnect;
			clkCfg_ff.vcoBypassed  <= (nxt_clkMode == CM_PRESCALER);
			// multiplier only applies when the vco tracks the oscillator
			clkCfg_ff.pllMultN     <= (nxt_clkMode == CM_PLL) ? pll_ff.pllMultiplier
			                                                  : 6'h01;
			clkCfg_ff.preDivP      <= (nxt_clkMode == CM_PLL_BASE) ? 4'h1 : P_FACTOR;
			clkCfg_ff.postDivK     <= K_FACTOR;
			clkCfg_ff.oscSourceExt <= ctrl_ff.extOscSelect;
			clkCfg_ff.oscEnable    <= (powerMode != PM_POWERDOWN);
			clkCfg_ff.pllEnable    <= (powerMode != PM_POWERDOWN);
		end
	end

	// clock enables: f_sys, a third of it for cpu and peripherals, slow-down on top
	assign sysRun    = (powerMode != PM_POWERDOWN);
	assign slowRatio = (powerMode == PM_SLOWDOWN) ? ctrl_ff.slowdownFactor
	                                              : SLOWDOWN_NONE;

	cmbs_tick_div u_base_div (
		.clk_sys(clk_sys),
		.rstn   (rstn),
		.tickIn (sysRun),
		.ratio  (SYS_TO_CPU_DIV),
		.tickOut(baseTick)
	);

	cmbs_tick_div u_slow_div (
		.clk_sys(clk_sys),
		.rstn   (rstn),
		.tickIn (baseTick),
		.ratio  (slowRatio),
		.tickOut(slowTick)
	);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cpuTick_ff    <= 1'b0;
			periphTick_ff <= 1'b0;
			ccuTick_ff    <= 1'b0;
			flashTick_ff  <= 1'b0;
		end
		else
		begin
			cpuTick_ff    <= slowTick && (powerMode != PM_IDLE);
			periphTick_ff <= slowTick;
			ccuTick_ff    <= slowTick;
			flashTick_ff  <= sysRun;
		end
	end

	// clock output pin with optional toggle latch
	always_comb
	begin
		unique case (cmbs_clock_output_pin_sel_type'(ctrl_ff.clkOutSel))
			CO_SYS:    selTick = sysRun;
			CO_CPU:    selTick = cpuTick_ff;
			CO_PERIPH: selTick = periphTick_ff;
			CO_FLASH:  selTick = flashTick_ff;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			clock_output_pin_ff   <= 1'b0;
			clkOutOe_ff <= 1'b0;
		end
		else
		begin
			// pin is a strap input until the boot option is latched
			clkOutOe_ff <= ctrl_ff.clkOutEnable && boot_ff.bootValid;
			if (ctrl_ff.toggleLatchEnable)
			begin
				if (selTick)
					clock_output_pin_ff <= !clock_output_pin_ff;
			end
			else
				clock_output_pin_ff <= selTick;
		end
	end

	// fail-safe detection: sticky flags, set wins over clear
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			oscRunPrev_ff  <= 1'b0;
			pllLockPrev_ff <= 1'b0;
			oscFail_ff     <= 1'b0;
			lockLost_ff    <= 1'b0;
		end
		else
		begin
			oscRunPrev_ff  <= statSync[1];
			pllLockPrev_ff <= statSync[0];
			if (oscRunPrev_ff && !statSync[1] && sysRun)
				oscFail_ff <= 1'b1;
			else if (wrPend_ff && wrAddr_ff == REG_STATUS_ADDR && hwdata[ST_OSC_FAIL_BIT])
				oscFail_ff <= 1'b0;
			if (pllLockPrev_ff && !statSync[0] && clkCfg_ff.clkMode == CM_PLL && sysRun)
				lockLost_ff <= 1'b1;
			else if (wrPend_ff && wrAddr_ff == REG_STATUS_ADDR && hwdata[ST_LOCK_LOST_BIT])
				lockLost_ff <= 1'b0;
		end
	end

	// ahb-lite slave: reads answered from a flop in the data phase
	assign addrPhase = hsel && htrans[1] && hready;

	always_comb
	begin
		readMux = 32'h0000_0000;
		unique case (haddr[7:0])
			REG_CTRL_ADDR:   readMux[CTRL_WIDTH-1:0] = ctrl_ff;
			REG_PLL_ADDR:    readMux[PLL_WIDTH-1:0]  = pll_ff;
			REG_STATUS_ADDR: readMux[STATUS_WIDTH-1:0] = {boot_ff.debugRefused, lockLost_ff,
			                     oscFail_ff, statSync[0], statSync[1], 1'b0, powerMode,
			                     clkCfg_ff.clkMode};
			REG_BOOT_ADDR:   readMux = {boot_ff.pcStart, 11'h000, boot_ff.debugRefused,
			                     boot_ff.jtagPinsActive, boot_ff.bootValid, boot_ff.bootMode};
			default:         readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPend_ff    <= 1'b0;
			wrAddr_ff    <= 8'h00;
			rdata_ff     <= 32'h0000_0000;
			hreadyout_ff <= 1'b0;
		end
		else
		begin
			hreadyout_ff <= 1'b1;
			wrPend_ff    <= addrPhase && hwrite;
			if (addrPhase)
				wrAddr_ff <= haddr[7:0];
			if (addrPhase && !hwrite)
				rdata_ff <= readMux;
		end
	end

	// software registers written in the data phase
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_ff <= cmbs_ctrl_type'(CTRL_RESET);
			pll_ff  <= cmbs_pll_type'(PLL_RESET);
		end
		else if (wrPend_ff)
		begin
			if (wrAddr_ff == REG_CTRL_ADDR)
				ctrl_ff <= cmbs_ctrl_type'(hwdata[CTRL_WIDTH-1:0]);
			if (wrAddr_ff == REG_PLL_ADDR)
				pll_ff <= cmbs_pll_type'(hwdata[PLL_WIDTH-1:0]);
		end
	end

	assign hrdata                = rdata_ff;
	assign hreadyout             = hreadyout_ff;
	assign hresp                 = 1'b0;
	assign clockOutputPinOut     = clock_output_pin_ff;
	assign clockOutputPinOe      = clkOutOe_ff;
	assign bootInfo              = boot_ff;
	assign clkCfg                = clkCfg_ff;
	assign cpuClkTick            = cpuTick_ff;
	assign periphClkTick         = periphTick_ff;
	assign captureCompareClkTick = ccuTick_ff;
	assign flashFastClkTick      = flashTick_ff;
endmodule : cmbs_core

// ### core/cmbs_pkg.sv
// cmbs_pkg: register map, field layouts, reset values, mode encodings and
// fixed divider factors for the clock mode and boot select block.
// assumes a 32-bit AHB-Lite register window decoded on the low address byte.
package cmbs_pkg;

	// register byte offsets
	localparam logic [7:0]  REG_CTRL_ADDR   = 8'h00;
	localparam logic [7:0]  REG_PLL_ADDR    = 8'h04;
	localparam logic [7:0]  REG_STATUS_ADDR = 8'h08;
	localparam logic [7:0]  REG_BOOT_ADDR   = 8'h0C;

	// field widths and positions
	localparam int          CTRL_WIDTH      = 11;
	localparam int          PLL_WIDTH       = 8;
	localparam int          STATUS_WIDTH    = 10;
	localparam int          ST_OSC_FAIL_BIT = 7;
	localparam int          ST_LOCK_LOST_BIT = 8;
	localparam int          BOOT_PC_LSB     = 16;

	// fixed factors and timing
	localparam logic [3:0]  P_FACTOR        = 4'h1;
	localparam logic [3:0]  K_FACTOR        = 4'h2;
	localparam logic [3:0]  SYS_TO_CPU_DIV  = 4'h3;
	localparam logic [3:0]  SLOWDOWN_NONE   = 4'h1;
	localparam logic [1:0]  BOOT_SETTLE_CYC = 2'h3;
	localparam logic [15:0] PC_START        = 16'h0000;

	typedef enum logic [1:0] {
		CM_PLL       = 2'b00,
		CM_PRESCALER = 2'b01,
		CM_PLL_BASE  = 2'b11
	} cmbs_clk_mode_type;

	typedef enum logic [1:0] {
		BM_USER      = 2'b00,
		BM_LOADER    = 2'b01,
		BM_DEBUG     = 2'b11,
		BM_USER_JTAG = 2'b10
	} cmbs_boot_mode_type;

	typedef enum logic [1:0] {
		PM_ACTIVE    = 2'b00,
		PM_IDLE      = 2'b01,
		PM_SLOWDOWN  = 2'b11,
		PM_POWERDOWN = 2'b10
	} cmbs_power_mode_type;

	typedef enum logic [1:0] {
		CO_SYS    = 2'b00,
		CO_CPU    = 2'b01,
		CO_PERIPH = 2'b11,
		CO_FLASH  = 2'b10
	} cmbs_clock_output_pin_sel_type;

	typedef enum logic [1:0] {
		BP_SYNC  = 2'b00,
		BP_LATCH = 2'b01,
		BP_DONE  = 2'b11
	} cmbs_boot_phase_type;

	// control register, bit 0 upward: slowdown, extOsc, toggle_latch_enable, clkOutSel, clkOutEn, powerMode
	typedef struct packed {
		logic [1:0] powerMode;
		logic       clkOutEnable;
		logic [1:0] clkOutSel;
		logic       toggleLatchEnable;
		logic       extOscSelect;
		logic [3:0] slowdownFactor;
	} cmbs_ctrl_type;

	// pll register, bit 0 upward: oscDisconnect, vcoBypass, multiplier
	typedef struct packed {
		logic [5:0] pllMultiplier;
		logic       vcoBypass;
		logic       oscDisconnect;
	} cmbs_pll_type;

	typedef struct packed {
		logic [15:0] pcStart;
		logic [1:0]  bootMode;
		logic        bootValid;
		logic        jtagPinsActive;
		logic        debugRefused;
	} cmbs_boot_type;

	typedef struct packed {
		logic [1:0] clkMode;
		logic       oscToPll;
		logic       vcoBypassed;
		logic [5:0] pllMultN;
		logic [3:0] preDivP;
		logic [3:0] postDivK;
		logic       oscSourceExt;
		logic       oscEnable;
		logic       pllEnable;
	} cmbs_clk_cfg_type;

	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h001;
	localparam logic [PLL_WIDTH-1:0]  PLL_RESET  = 8'h3C;

endpackage : cmbs_pkg

// ### core/cmbs_sync2.sv
// cmbs_sync2: two-flop synchroniser for levels arriving from pins.
// assumes the inputs are quasi-static levels; no pulse capture.
`timescale 1ns/1ps
module cmbs_sync2 #(
	parameter int WIDTH = 1
) (
	input  logic             clk_sys, // system clock
	input  logic             rstn,    // async reset, active low
	input  logic [WIDTH-1:0] asyncIn, // level from outside the domain
	output logic [WIDTH-1:0] syncOut  // synchronised level
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;
endmodule : cmbs_sync2

// ### core/cmbs_tick_div.sv
// cmbs_tick_div: divides a stream of enable ticks by a programmable ratio.
// assumes ratio zero behaves as one; output is a one-cycle registered pulse.
`timescale 1ns/1ps
module cmbs_tick_div (
	input  logic       clk_sys, // system clock
	input  logic       rstn,    // async reset, active low
	input  logic       tickIn,  // input tick stream
	input  logic [3:0] ratio,   // division ratio
	output logic       tickOut  // one tick per ratio input ticks
);
	logic [3:0] cnt_ff;
	logic       tickOut_ff;
	logic [3:0] ratioEff;

	assign ratioEff = (ratio == 4'h0) ? 4'h1 : ratio;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_ff     <= 4'h0;
			tickOut_ff <= 1'b0;
		end
		else
		begin
			tickOut_ff <= 1'b0;
			if (tickIn)
			begin
				if (cnt_ff >= ratioEff - 4'h1)
				begin
					cnt_ff     <= 4'h0;
					tickOut_ff <= 1'b1;
				end
				else
				begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
		end
	end

	assign tickOut = tickOut_ff;
endmodule : cmbs_tick_div

// ### tb/cmbs_core_properties.sv
// cmbs_core_properties: port-level assertions for the clock mode and boot block.
// assumes it is bound to cmbs_core; one clock domain, rstn async active low.
`timescale 1ns/1ps
module cmbs_core_checker
	import cmbs_pkg::*;
(
	input logic             clk_sys,               // system clock
	input logic             rstn,                  // async reset, active low
	input cmbs_boot_type    bootInfo,              // latched boot option
	input cmbs_clk_cfg_type clkCfg,                // clock path configuration
	input logic             cpuClkTick,            // cpu tick
	input logic             periphClkTick,         // peripheral tick
	input logic             captureCompareClkTick, // capture-compare tick
	input logic             clockOutputPinOe       // clock output enable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_boot_hold: assert property (bootInfo.bootValid |=> bootInfo.bootValid && $stable(bootInfo))
		else $error("boot option changed after latch");
	a_pc_zero: assert property (bootInfo.bootValid |-> bootInfo.pcStart == PC_START)
		else $error("start address not zero");
	a_debug_refused: assert property (bootInfo.debugRefused |-> bootInfo.bootMode != BM_DEBUG)
		else $error("refused debug mode entered");
	a_jtag_active: assert property (bootInfo.bootMode == BM_USER_JTAG && bootInfo.bootValid
		|-> bootInfo.jtagPinsActive)
		else $error("jtag pins inactive in jtag user mode");
	a_disc_base: assert property (bootInfo.bootValid && !clkCfg.oscToPll
		|-> clkCfg.clkMode == CM_PLL_BASE)
		else $error("disconnected osc not in base mode");
	a_bypass_mode: assert property (bootInfo.bootValid && clkCfg.oscToPll
		|-> clkCfg.clkMode == (clkCfg.vcoBypassed ? CM_PRESCALER : CM_PLL))
		else $error("clock mode does not follow bits");
	a_fixed_divs: assert property (bootInfo.bootValid
		|-> clkCfg.preDivP == P_FACTOR && clkCfg.postDivK == K_FACTOR)
		else $error("fixed dividers wrong");
	a_periph_spacing: assert property (periphClkTick |=> !periphClkTick [*2])
		else $error("peripheral tick faster than a third");
	a_cpu_in_periph: assert property (cpuClkTick |-> periphClkTick)
		else $error("cpu tick without peripheral tick");
	a_ccu_common: assert property (captureCompareClkTick == periphClkTick)
		else $error("capture-compare tick differs");
	a_clock_output_pin_oe: assert property (clockOutputPinOe |-> bootInfo.bootValid)
		else $error("clock output driven before boot latch");
endmodule : cmbs_core_checker

bind cmbs_core cmbs_core_checker cmbs_core_checker_i (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.bootInfo(bootInfo),
	.clkCfg(clkCfg),
	.cpuClkTick(cpuClkTick),
	.periphClkTick(periphClkTick),
	.captureCompareClkTick(captureCompareClkTick),
	.clockOutputPinOe(clockOutputPinOe)
);

// ### tb/cmbs_pin_model.sv
// cmbs_pin_model: strap pins, shared port0 pin and oscillator/pll detectors.
// assumes the bench sets strap levels and failure requests.
`timescale 1ns/1ps
module cmbs_pin_model (
	input  wire logic [2:0] strapLevels, // mode-boot, tms, port0 levels
	input  wire logic       oscStop,     // oscillator stops
	input  wire logic       lockDrop,    // pll loses lock
	input  wire logic       pinOut,      // device level on port0 pin
	input  wire logic       pinOe,       // device drives port0 pin
	output logic            modeBootPin, // mode-boot strap
	output logic            tmsPin,      // test-mode-select strap
	output logic            port0Pin,    // resolved port0 level
	output logic            oscRunning,  // oscillator run detector
	output logic            pllLocked    // pll lock detector
);
	assign modeBootPin = strapLevels[2];
	assign tmsPin = strapLevels[1];
	// device drive wins while enabled, else the strap resistor level
	assign port0Pin = pinOe ? pinOut : strapLevels[0];
	assign oscRunning = !oscStop;
	assign pllLocked = !lockDrop;
endmodule : cmbs_pin_model

// ### tb/tb_clock_mode_and_boot_select.sv
// tb_clock_mode_and_boot_select: boot straps, clock modes and ticks over AHB-Lite.
// assumes cmbs_core with no wait states; ticks are counted at the falling edge.
`timescale 1ns/1ps
module tb_clock_mode_and_boot_select
	import cmbs_pkg::*;
;
	logic clk_sys = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, flashProtected = 1'h0;
	logic oscStop = 1'h0, lockDrop = 1'h0, hreadyout, hresp, pinOut, pinOe;
	logic modeBootPin, tmsPin, port0Pin, oscRunning, pllLocked;
	logic cpuClkTick, periphClkTick, captureCompareClkTick, flashFastClkTick;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  strap = 3'h5;
	logic [7:0]  nCpu, nPer, nCcu, nFl, nPin;
	cmbs_boot_type    bootInfo;
	cmbs_clk_cfg_type clkCfg;
	int failures = 0, checked = 0;
	logic [3:0]  bootCase [5] = '{4'hA, 4'h0, 4'h4, 4'h5, 4'hC};
	logic [7:0]  bootExp [5] = '{8'h04, 8'h05, 8'h0F, 8'h14, 8'h0E};
	logic [7:0]  pllVal [4] = '{8'h3E, 8'h3D, 8'h3F, 8'h78};
	logic [1:0]  modeExp [4] = '{2'h1, 2'h3, 2'h3, 2'h0};
	logic [31:0] ctrlVal [5] = '{32'h001, 32'h201, 32'h602, 32'h401, 32'h001};
	logic [31:0] tickExp [5] = '{32'h1414143C, 32'h0014143C, 32'h0A0A0A3C, 32'h0, 32'h1414143C};
	logic [31:0] outVal [4] = '{32'h101, 32'h141, 32'h1E1, 32'h1A1};
	logic [7:0]  pinExp [4] = '{8'h3C, 8'h14, 8'h1E, 8'h1E};

	always #12.5 clk_sys = ~clk_sys;

	cmbs_core cmbs_core_i (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .modeBootPin(modeBootPin),
		.tmsPin(tmsPin), .port0FirstPinIn(port0Pin), .clockOutputPinOut(pinOut),
		.clockOutputPinOe(pinOe), .flashProtected(flashProtected), .oscRunning(oscRunning),
		.pllLocked(pllLocked), .bootInfo(bootInfo), .clkCfg(clkCfg), .cpuClkTick(cpuClkTick),
		.periphClkTick(periphClkTick), .captureCompareClkTick(captureCompareClkTick),
		.flashFastClkTick(flashFastClkTick));
	cmbs_pin_model cmbs_pin_model_i (.strapLevels(strap), .oscStop(oscStop),
		.lockDrop(lockDrop), .pinOut(pinOut), .pinOe(pinOe), .modeBootPin(modeBootPin),
		.tmsPin(tmsPin), .port0Pin(port0Pin), .oscRunning(oscRunning), .pllLocked(pllLocked));

	task test_done;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : xfer

	task bootRun(input logic [3:0] c);
		rstn <= 1'h0;
		strap <= c[3:1];
		flashProtected <= c[0];
		repeat (16) @(posedge clk_sys);
		rstn <= 1'h1;
		repeat (6) @(posedge clk_sys);
	endtask : bootRun

	task measure(input logic [31:0] exp);
		repeat (8) @(posedge clk_sys);
		{nCpu, nPer, nCcu, nFl, nPin} = '0;
		repeat (60)
		begin
			@(negedge clk_sys);
			nCpu += 8'(cpuClkTick);
			nPer += 8'(periphClkTick);
			nCcu += 8'(captureCompareClkTick);
			nFl += 8'(flashFastClkTick);
			nPin += 8'(pinOut);
		end
		chk({nCpu, nPer, nCcu, nFl}, exp);
	endtask : measure

	initial
	begin
		#(25 * 20000);
		failures++;
		test_done;
	end

	initial
	begin
		for (int i = 0; i < 5; i++)
		begin
			bootRun(bootCase[i]);
			xfer(REG_BOOT_ADDR, 1'h0, 32'h0);
			chk(rd, 32'(bootExp[i]));
		end
		strap <= 3'h0;
		repeat (8) @(posedge clk_sys);
		xfer(REG_BOOT_ADDR, 1'h0, 32'h0);
		chk(rd, 32'h0E);
		xfer(REG_CTRL_ADDR, 1'h0, 32'h0);
		chk(rd, 32'h001);
		xfer(REG_PLL_ADDR, 1'h0, 32'h0);
		chk(rd, 32'h3C);
		xfer(8'h10, 1'h1, 32'hFFFFFFFF);
		xfer(8'h10, 1'h0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		chk(32'(clkCfg.oscSourceExt), 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			xfer(REG_PLL_ADDR, 1'h1, 32'(pllVal[i]));
			xfer(REG_STATUS_ADDR, 1'h0, 32'h0);
			chk(32'(rd[1:0]), 32'(modeExp[i]));
			chk(32'({clkCfg.oscToPll, clkCfg.vcoBypassed}),
				32'({!pllVal[i][0], modeExp[i] == 2'h1}));
		end
		chk(32'(clkCfg.pllMultN), 32'h1E);
		xfer(REG_PLL_ADDR, 1'h1, 32'h3C);
		xfer(REG_CTRL_ADDR, 1'h1, 32'h011);
		repeat (3) @(posedge clk_sys);
		chk(32'(clkCfg.oscSourceExt), 32'h1);
		xfer(REG_CTRL_ADDR, 1'h1, 32'h001);
		oscStop <= 1'h1;
		repeat (6) @(posedge clk_sys);
		oscStop <= 1'h0;
		repeat (6) @(posedge clk_sys);
		xfer(REG_STATUS_ADDR, 1'h0, 32'h0);
		chk(32'(rd[8:5]), 32'h7);
		lockDrop <= 1'h1;
		repeat (6) @(posedge clk_sys);
		lockDrop <= 1'h0;
		repeat (6) @(posedge clk_sys);
		xfer(REG_STATUS_ADDR, 1'h0, 32'h0);
		chk(32'(rd[8:5]), 32'hF);
		xfer(REG_STATUS_ADDR, 1'h1, 32'h180);
		xfer(REG_STATUS_ADDR, 1'h0, 32'h0);
		chk(32'(rd[8:5]), 32'h3);
		for (int i = 0; i < 5; i++)
		begin
			xfer(REG_CTRL_ADDR, 1'h1, ctrlVal[i]);
			measure(tickExp[i]);
			if (i == 3)
				chk(32'({clkCfg.oscEnable, clkCfg.pllEnable}), 32'h0);
		end
		for (int i = 0; i < 4; i++)
		begin
			xfer(REG_CTRL_ADDR, 1'h1, outVal[i]);
			measure(32'h1414143C);
			chk(32'({pinOe, nPin}), 32'h100 | 32'(pinExp[i]));
		end
		test_done;
	end
endmodule : tb_clock_mode_and_boot_select
